// >>> src/data_space_address_decoder.sv
// Data-space address decoder with general purpose I/O registers
// ==========================================
`timescale 1ns/100ps
`default_nettype none
module data_space_address_decoder
	import data_decode_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  accValid,
	input  wire data_decode_pkg::access_type accKind,
	input  wire logic [15:0]           accAddr,
	input  wire logic                  accWrite,
	input  wire logic [7:0]            accWrData,
	input  wire logic [2:0]            bitIndex,
	input  wire logic                  bitSet,
	input  wire logic                  fetchValid,
	input  wire logic                  eeMapEnable,
	output logic                       ioSel,
	output logic                       eepromSel,
	output logic                       sramSel,
	output logic                       accFault,
	output logic                       bitOpAllowed,
	output logic                       gpSel,
	output logic [11:0]                ioAddr,
	output logic [11:0]                eepromAddr,
	output logic [15:0]                sramAddr,
	output logic                       fetchDataSel,
	output logic [7:0]                 gpRdData,
	output logic                       bitTest
);
	data_decode_pkg::target_type target;
	logic       inIo;
	logic       inDirect;
	logic       inBit;
	logic       inGp;
	logic       inEe;
	logic       inSram;
	logic       isData;
	logic       isDirect;
	logic       isBit;
	logic [7:0] gpValue [GP_REG_COUNT];
	logic [7:0] gpRdData_q;
	logic       bitTest_q;

	// ==========================================
	// Address ranges
	assign inIo     = accAddr <= IO_LAST;
	assign inDirect = accAddr <= IO_DIRECT_LAST;
	assign inBit    = accAddr <= IO_BIT_LAST;
	assign inGp     = accAddr <= IO_GP_LAST;
	assign inEe     = (accAddr >= EEPROM_BASE) && (accAddr <= EEPROM_LAST);
	assign inSram   = accAddr >= SRAM_BASE;
	assign isData   = accValid && (accKind == ACC_DATA);
	assign isDirect = accValid && (accKind == ACC_DIRECT);
	assign isBit    = accValid && (accKind == ACC_BIT);

	// ==========================================
	// Target choice, one target at most
	always_comb begin
		target = TGT_NONE;
		if (isData) begin
			if (inIo) begin
				target = TGT_IO;
			end else if (inEe) begin
				// Unmapped EEPROM window stays empty so the separate space is the only path
				target = eeMapEnable ? TGT_EEPROM : TGT_NONE;
			end else if (inSram) begin
				target = TGT_SRAM;
			end
		end else if (isDirect && inDirect) begin
			target = TGT_IO;
		end else if (isBit && inBit) begin
			target = TGT_IO;
		end
	end

	assign ioSel        = target == TGT_IO;
	assign eepromSel    = target == TGT_EEPROM;
	assign sramSel      = target == TGT_SRAM;
	assign accFault     = accValid && (target == TGT_NONE);
	assign bitOpAllowed = isBit && inBit;
	assign gpSel        = ioSel && inGp;
	// Same register whether reached directly or through data space
	assign ioAddr       = accAddr[11:0];
	assign eepromAddr   = accAddr[11:0] - EEPROM_BASE[11:0];
	assign sramAddr     = accAddr - SRAM_BASE;
	// Fetches go to program memory only; data-space selects ignore them
	assign fetchDataSel = 1'b0;

	// ==========================================
	// General purpose registers
	genvar g;
	generate
		for (g = 0; g < GP_REG_COUNT; g++) begin : gGp
			gp_io_reg uReg (
				.mclk     (mclk),
				.rst      (rst),
				.wrEn     (gpSel && !isBit && accWrite && (accAddr[3:0] == 4'(g))),
				.wrData   (accWrData),
				.bitEn    (gpSel && isBit && accWrite && (accAddr[3:0] == 4'(g))),
				.bitValue (bitSet),
				.bitIndex (bitIndex),
				.value    (gpValue[g])
			);
		end
	endgenerate

	// Read data registered: one cycle after the select
	always_ff @(posedge mclk) begin
		if (rst) begin
			gpRdData_q <= 8'h00;
			bitTest_q  <= 1'b0;
		end else begin
			gpRdData_q <= gpSel ? gpValue[accAddr[3:0]] : 8'h00;
			bitTest_q  <= gpSel && isBit && gpValue[accAddr[3:0]][bitIndex];
		end
	end

	assign gpRdData = gpRdData_q;
	assign bitTest  = bitTest_q;

	// ==========================================
	// Checks
	a_one_target: assert property (@(posedge mclk) disable iff (rst)
		$onehot0({ioSel, eepromSel, sramSel})) else $error("more than one target");
	a_ext_direct: assert property (@(posedge mclk) disable iff (rst)
		(isDirect && accAddr >= EXT_IO_FIRST) |-> !ioSel) else $error("direct reached extended io");
	a_low_io: assert property (@(posedge mclk) disable iff (rst)
		(isData && accAddr <= IO_LAST) |-> ioSel) else $error("low 4KB not io");
	a_ee_map: assert property (@(posedge mclk) disable iff (rst)
		(isData && inEe) |-> (eepromSel == eeMapEnable)) else $error("eeprom map wrong");
	a_ee_base: assert property (@(posedge mclk) disable iff (rst)
		(eepromSel && accAddr == EEPROM_BASE) |-> eepromAddr == 12'h000) else $error("eeprom base");
	a_sram_sel: assert property (@(posedge mclk) disable iff (rst)
		(isData && accAddr >= SRAM_BASE) |-> (sramSel && sramAddr == accAddr - SRAM_BASE))
		else $error("sram not selected");
	a_no_fetch: assert property (@(posedge mclk) disable iff (rst)
		fetchValid |-> !fetchDataSel) else $error("fetch hit data");
	a_bit_range: assert property (@(posedge mclk) disable iff (rst)
		(isBit && accAddr > IO_BIT_LAST) |-> (!bitOpAllowed && accFault)) else $error("bit op range");
	a_gp_write: assert property (@(posedge mclk) disable iff (rst)
		(gpSel && !isBit && accWrite) |=>
			(gpValue[$past(accAddr[3:0])] == $past(accWrData))) else $error("gp write lost");
	a_gp_bit: assert property (@(posedge mclk) disable iff (rst)
		(gpSel && isBit && accWrite) |=>
			(gpValue[$past(accAddr[3:0])][$past(bitIndex)] == $past(bitSet))) else $error("gp bit lost");
	a_ext_data: assert property (@(posedge mclk) disable iff (rst)
		(isData && accAddr >= EXT_IO_FIRST && accAddr <= IO_LAST) |-> (ioSel && ioAddr == accAddr[11:0]))
		else $error("extended io not reached by data");
	a_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
		!accValid |-> !(ioSel || eepromSel || sramSel || accFault)) else $error("select without access");
	a_fault_alone: assert property (@(posedge mclk) disable iff (rst)
		accFault |-> !(ioSel || eepromSel || sramSel)) else $error("fault with select");
	a_direct_same: assert property (@(posedge mclk) disable iff (rst)
		(isDirect && inDirect) |-> (ioSel && ioAddr == accAddr[11:0])) else $error("direct mismatch");
endmodule : data_space_address_decoder
`default_nettype wire

// >>> src/data_decode_pkg.sv
// Address map constants and types for the data-space address decoder
package data_decode_pkg;
	// ==========================================
	// Address map
	localparam int          ADDR_WIDTH      = 16;
	localparam logic [15:0] IO_BASE         = 16'h0000;
	localparam logic [15:0] IO_DIRECT_LAST  = 16'h003F;
	localparam logic [15:0] IO_BIT_LAST     = 16'h001F;
	localparam logic [15:0] IO_GP_LAST      = 16'h000F;
	localparam logic [15:0] EXT_IO_FIRST    = 16'h0040;
	localparam logic [15:0] IO_LAST         = 16'h0FFF;
	localparam logic [15:0] EEPROM_BASE     = 16'h1000;
	localparam logic [15:0] EEPROM_LAST     = 16'h1FFF;
	localparam logic [15:0] SRAM_BASE       = 16'h2000;
	localparam int          GP_REG_COUNT    = 16;
	localparam logic [7:0]  GP_RESET_VALUE  = 8'h00;
	localparam logic [1:0]  EE_MAP_RESET    = 2'h0;

	// ==========================================
	// Access kinds from the core
	typedef enum logic [2:0] {
		ACC_DATA   = 3'h1,
		ACC_DIRECT = 3'h2,
		ACC_BIT    = 3'h4
	} access_type;

	// Selected target, one-hot
	typedef enum logic [3:0] {
		TGT_NONE   = 4'h1,
		TGT_IO     = 4'h2,
		TGT_EEPROM = 4'h4,
		TGT_SRAM   = 4'h8
	} target_type;
endpackage : data_decode_pkg

// >>> src/gp_io_reg.sv
// One general purpose I/O storage register with bit set and clear
`timescale 1ns/100ps
`default_nettype none
module gp_io_reg
	import data_decode_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	input  wire logic       bitEn,
	input  wire logic       bitValue,
	input  wire logic [2:0] bitIndex,
	output var  logic [7:0] value
);
	logic [7:0] value_q;

	// ==========================================
	// Storage, no side effects on read
	always_ff @(posedge mclk) begin
		if (rst) begin
			value_q <= data_decode_pkg::GP_RESET_VALUE;
		end else if (wrEn) begin
			value_q <= wrData;
		end else if (bitEn) begin
			value_q[bitIndex] <= bitValue;
		end
	end

	assign value = value_q;
endmodule : gp_io_reg
`default_nettype wire

// >>> bench/core_access_model.sv
// Core-side model that issues data-space and I/O accesses to the decoder
`timescale 1ns/100ps
`default_nettype none
module core_access_model (
	input  wire logic                   mclk,
	output logic                        accValid,
	output data_decode_pkg::access_type accKind,
	output logic [15:0]                 accAddr,
	output logic                        accWrite,
	output logic [7:0]                  accWrData,
	output logic [2:0]                  bitIndex,
	output logic                        bitSet
);
	import data_decode_pkg::*;
	initial begin
		accValid = 1'b0;
		accKind = ACC_DATA;
		accAddr = 16'h0000;
		accWrite = 1'b0;
		accWrData = 8'h00;
		bitIndex = 3'h0;
		bitSet = 1'b0;
	end
	// ==========================================
	// One access, held until the next call; direct forms stay below 0x40 unless a refusal is wanted
	task automatic issue(input access_type k, input logic [15:0] a, input logic w, input logic [7:0] d,
		input logic [2:0] i, input logic s);
		@(posedge mclk);
		accValid <= 1'b1;
		accKind <= k;
		accAddr <= a;
		accWrite <= w;
		accWrData <= d;
		bitIndex <= i;
		bitSet <= s;
		#1;
	endtask : issue
	// Released bus shows the inverse so a stale address never looks valid
	task automatic idle();
		@(posedge mclk);
		accValid <= 1'b0;
		accAddr <= ~accAddr;
	endtask : idle
endmodule : core_access_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench for the data-space address decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import data_decode_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, fetchValid = 1'b0, eeMapEnable = 1'b0;
	logic accValid, accWrite, bitSet, ioSel, eepromSel, sramSel, accFault, bitOpAllowed, gpSel, fetchDataSel, bitTest;
	access_type accKind;
	logic [15:0] accAddr, sramAddr;
	logic [11:0] ioAddr, eepromAddr;
	logic [7:0] accWrData, gpRdData;
	logic [2:0] bitIndex;
	int nMismatch = 0, checkCount = 0;
	always #4 mclk = ~mclk;
	core_access_model core (.mclk(mclk), .accValid(accValid), .accKind(accKind), .accAddr(accAddr),
		.accWrite(accWrite), .accWrData(accWrData), .bitIndex(bitIndex), .bitSet(bitSet));
	data_space_address_decoder dut (.mclk(mclk), .rst(rst), .accValid(accValid), .accKind(accKind),
		.accAddr(accAddr), .accWrite(accWrite), .accWrData(accWrData), .bitIndex(bitIndex), .bitSet(bitSet),
		.fetchValid(fetchValid), .eeMapEnable(eeMapEnable), .ioSel(ioSel), .eepromSel(eepromSel),
		.sramSel(sramSel), .accFault(accFault), .bitOpAllowed(bitOpAllowed), .gpSel(gpSel), .ioAddr(ioAddr),
		.eepromAddr(eepromAddr), .sramAddr(sramAddr), .fetchDataSel(fetchDataSel), .gpRdData(gpRdData),
		.bitTest(bitTest));
	// ==========================================
	// Shared checks
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checkCount++;
		if (e !== s) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Selects packed as io, eeprom, sram, fault
	task automatic look(input access_type k, input logic [15:0] a, input logic [3:0] e);
		core.issue(k, a, 1'b0, 8'h00, 3'h0, 1'b0);
		chk("sel", {12'h000, e}, {12'h000, ioSel, eepromSel, sramSel, accFault});
	endtask : look
	task automatic finish_test();
		if (nMismatch == 0 && checkCount > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// ==========================================
	// Scenarios
	task automatic t_regions();
		look(ACC_DATA, 16'h0000, 4'h8);
		look(ACC_DATA, 16'h0FFF, 4'h8);
		chk("ioAddr", 16'h0FFF, {4'h0, ioAddr});
		look(ACC_DATA, 16'h1000, 4'h1);
		look(ACC_DATA, 16'h2003, 4'h2);
		chk("sramAddr", 16'h0003, sramAddr);
		look(ACC_DATA, 16'hFFFF, 4'h2);
	endtask : t_regions
	task automatic t_direct();
		look(ACC_DIRECT, 16'h003F, 4'h8);
		look(ACC_DIRECT, 16'h0040, 4'h1);
		look(ACC_DATA, 16'h0040, 4'h8);
	endtask : t_direct
	task automatic t_eemap();
		@(posedge mclk) eeMapEnable <= 1'b1;
		look(ACC_DATA, 16'h1000, 4'h4);
		chk("eepromAddr", 16'h0000, {4'h0, eepromAddr});
		look(ACC_DATA, 16'h1FFF, 4'h4);
		chk("eepromAddr", 16'h0FFF, {4'h0, eepromAddr});
		@(posedge mclk) eeMapEnable <= 1'b0;
	endtask : t_eemap
	task automatic t_fetch();
		@(posedge mclk) fetchValid <= 1'b1;
		look(ACC_DATA, 16'h2000, 4'h2);
		chk("fetchDataSel", 16'h0000, {15'h0000, fetchDataSel});
		@(posedge mclk) fetchValid <= 1'b0;
	endtask : t_fetch
	// Write, read back, clear a bit, then test a bit; data form and direct form reach one register
	task automatic t_gp();
		core.issue(ACC_DIRECT, 16'h0003, 1'b0, 8'h00, 3'h0, 1'b0);
		chk("gpSel", 16'h0001, {15'h0000, gpSel});
		core.issue(ACC_DATA, 16'h0005, 1'b1, 8'hA5, 3'h0, 1'b0);
		chk("gpRdData", 16'h0000, {8'h00, gpRdData});
		core.issue(ACC_DIRECT, 16'h0005, 1'b0, 8'h00, 3'h0, 1'b0);
		core.issue(ACC_BIT, 16'h0005, 1'b1, 8'h00, 3'h0, 1'b0);
		chk("gpRdData", 16'h00A5, {8'h00, gpRdData});
		chk("bitOpAllowed", 16'h0001, {15'h0000, bitOpAllowed});
		core.issue(ACC_DATA, 16'h0005, 1'b0, 8'h00, 3'h0, 1'b0);
		core.issue(ACC_BIT, 16'h0005, 1'b0, 8'h00, 3'h2, 1'b0);
		chk("gpRdData", 16'h00A4, {8'h00, gpRdData});
		core.idle();
		#1 chk("bitTest", 16'h0001, {15'h0000, bitTest});
		look(ACC_BIT, 16'h001F, 4'h8);
		look(ACC_BIT, 16'h0020, 4'h1);
		core.issue(ACC_BIT, 16'h0005, 1'b1, 8'h00, 3'h1, 1'b1);
		core.issue(ACC_DATA, 16'h0005, 1'b0, 8'h00, 3'h0, 1'b0);
		core.idle();
		#1 chk("gpRdData", 16'h00A6, {8'h00, gpRdData});
	endtask : t_gp
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_gp();
		t_regions();
		t_direct();
		t_eemap();
		t_fetch();
		finish_test();
	end
	// Whole run needs under a hundred cycles
	initial begin
		#(8 * 2000);
		nMismatch++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
